// File: core/fsr_pkg.sv
// Constants for the flash status register bank: bit layout, opcodes,
// frame bit counts and the internal write timing.
// Assumes a 10 MHz reference clock and SPI mode 0 or 3 framing.
package fsr_pkg;

  // Status bit positions
  localparam int BUSY_BIT = 0;
  localparam int WPL_BIT = 1;
  localparam int PCODE_LSB = 2;
  localparam int PCODE_MSB = 5;
  localparam int QIO_BIT = 6;
  localparam int LOCK_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Instruction opcodes
  localparam logic [7:0] OPC_STATUS_READ = 8'h05;
  localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OPC_WRITE_PERMIT = 8'h06;
  localparam logic [7:0] OPC_WRITE_FORBID = 8'h04;
  localparam logic [7:0] OPC_FUNC_READ = 8'h48;
  localparam logic [7:0] OPC_EXTRD_READ = 8'h81;
  localparam logic [7:0] OPC_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OPC_RESET = 8'h99;
  localparam logic [7:0] OPC_SUSPEND = 8'h75;
  localparam logic [7:0] OPC_RESUME = 8'h7a;
  localparam logic [7:0] OPC_PROG = 8'h02;
  localparam logic [7:0] OPC_PROG_Q1 = 8'h32;
  localparam logic [7:0] OPC_PROG_Q2 = 8'h38;
  localparam logic [7:0] OPC_SEC_ERASE1 = 8'hd7;
  localparam logic [7:0] OPC_SEC_ERASE2 = 8'h20;
  localparam logic [7:0] OPC_BLK32_ERASE = 8'h52;
  localparam logic [7:0] OPC_BLK64_ERASE = 8'hd8;
  localparam logic [7:0] OPC_CHIP_ERASE1 = 8'hc7;
  localparam logic [7:0] OPC_CHIP_ERASE2 = 8'h60;

  // Frame bit counts
  localparam logic [5:0] BITS_CMD = 6'h08;
  localparam logic [5:0] BITS_WDATA = 6'h10;
  localparam logic [5:0] BITS_ADDR = 6'h20;
  localparam logic [5:0] BITS_MAX = 6'h3f;

  // Address fields
  localparam int SEC_MSB = 20;
  localparam int SEC_LSB = 12;
  localparam int BLK_LSB = 16;

  // Internal write time, least value, rounded up to clock cycles
  localparam int CLK_PERIOD_NS = 100;
  localparam int OP_TIME_US = 200;
  localparam logic [15:0] OP_CYCLES =
    16'((OP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b11,
    ST_SKIP = 2'b10
  } fsr_state_type;

endpackage

// File: core/fsr_protect.sv
// Block-protect decoder: maps the 4-bit protect code and a 64 KB block
// index onto a write-protect verdict.
// Assumes 32 blocks of 64 KB; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module fsr_protect (
  input wire logic [3:0] code_i,
  input wire logic [4:0] block_i,
  output logic prot_o
);
  // Codes 1 to 5 guard the top, a to e the bottom of the array; 6 to 9 guard all, 0 and f nothing
  always_comb begin
    unique case (code_i)
      4'h0: prot_o = 1'b0;
      4'h1: prot_o = (block_i >= 5'h1f);
      4'h2: prot_o = (block_i >= 5'h1e);
      4'h3: prot_o = (block_i >= 5'h1c);
      4'h4: prot_o = (block_i >= 5'h18);
      4'h5: prot_o = (block_i >= 5'h10);
      4'h6, 4'h7, 4'h8, 4'h9: prot_o = 1'b1;
      4'ha: prot_o = (block_i < 5'h10);
      4'hb: prot_o = (block_i < 5'h08);
      4'hc: prot_o = (block_i < 5'h04);
      4'hd: prot_o = (block_i < 5'h02);
      4'he: prot_o = (block_i == 5'h00);
      4'hf: prot_o = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// File: core/fsr_bank.sv
// Status register bank of a serial flash: SPI instruction intake,
// status readout, write-permit latch, non-volatile protect bits, busy.
// Assumes SPI pins synchronous to REF_CLK_I and SCK at most 2.5 MHz.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Repeat the status register, sampled afresh each byte, while a read frame stays selected
// - Bit 0 reads one while busy, zero when ready
// - Write-permit latch changes by permit and forbid instructions, at the end of a write and by software reset
// - Bits 2 to 5 select a protected area; zero protects nothing
// - Bit 6 set enables the quad data function
// - Bit 7 set makes the status register write-protected while the WP pin is low and quad is off
// - Bits 2 to 7 are non-volatile, changed only by status write
// - Non-volatile status bits start at zero
// - Status read returns all eight status bits
// - Busy is read-only, set through every program, erase, register write
// - While busy, drop all but register reads, resets and suspend
// - Suspend is accepted while a program or erase runs
// - Busy clears at the end of every operation
// - Permit latch set by permit instruction, cleared when an accepted write, program or erase ends; a rejected one leaves it set
module fsr_bank
  import fsr_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic CLK_EN_I,
  input wire logic SPI_SCK_I,
  input wire logic SPI_CE_N_I,
  input wire logic SPI_SI_I,
  input wire logic SPI_WP_N_I,
  output logic SPI_SO_O,
  output logic SPI_SO_OE_N_O,
  output logic QUAD_ON_O,
  output logic BUSY_O,
  output logic SUSPENDED_O,
  output logic OP_START_O,
  output logic [7:0] OP_CODE_O,
  output logic [8:0] OP_SECTOR_O,
  output logic [4:0] OP_BLOCK_O
);
  fsr_state_type state, next_state;
  logic sck_q, next_sck_q, ce_q, next_ce_q;
  logic [5:0] cnt, next_cnt;
  logic [7:0] sh, next_sh, cmd, next_cmd, wdata, next_wdata;
  logic [7:0] snap, next_snap;
  logic [23:0] addr, next_addr;
  logic [2:0] idx, next_idx;
  logic so, next_so, so_oe_n, next_so_oe_n;
  logic busy, next_busy, wpl, next_wpl, susp, next_susp, nvw, next_nvw;
  logic [5:0] nv, next_nv;
  logic [15:0] timer, next_timer;
  logic op_start, next_op_start;
  logic [7:0] op_code, next_op_code;
  logic [8:0] op_sector, next_op_sector;
  logic [4:0] op_block, next_op_block;
  logic rise, fall, ce_up, prot, wp_eff, exec, allowed;
  logic [7:0] status, in_byte;

  // Edge detection on sampled pins
  assign rise = SPI_SCK_I & ~sck_q & ~SPI_CE_N_I;
  assign fall = ~SPI_SCK_I & sck_q & ~SPI_CE_N_I;
  assign ce_up = SPI_CE_N_I & ~ce_q;
  assign exec = ce_up && (state != ST_SKIP) && (cnt >= BITS_CMD);
  assign in_byte = {sh[6:0], SPI_SI_I};
  assign status = {nv, wpl, busy};
  // Quad mode takes the write-protect pin away as a data line
  assign wp_eff = nv[QIO_BIT-2] | SPI_WP_N_I;

  // Instructions still heard while busy
  always_comb begin
    unique case (in_byte)
      OPC_STATUS_READ, OPC_FUNC_READ, OPC_EXTRD_READ, OPC_RESET_ENABLE,
      OPC_RESET, OPC_SUSPEND: allowed = 1'b1;
      default: allowed = 1'b0;
    endcase
  end

  fsr_protect u_protect (
    .code_i(nv[PCODE_MSB-2:PCODE_LSB-2]),
    .block_i(addr[SEC_MSB:BLK_LSB]),
    .prot_o(prot)
  );

  // Frame intake, readout and status state: next values
  always_comb begin
    next_state = state;
    next_sck_q = SPI_SCK_I;
    next_ce_q = SPI_CE_N_I;
    next_cnt = cnt;
    next_sh = sh;
    next_cmd = cmd;
    next_wdata = wdata;
    next_snap = snap;
    next_addr = addr;
    next_idx = idx;
    next_so = so;
    next_so_oe_n = so_oe_n;
    next_busy = busy;
    next_wpl = wpl;
    next_susp = susp;
    next_nvw = nvw;
    next_nv = nv;
    next_timer = timer;
    next_op_start = 1'b0;
    next_op_code = op_code;
    next_op_sector = op_sector;
    next_op_block = op_block;
    // Internal operation timer; suspended work keeps its remainder
    if (busy) begin
      if (timer == 16'h0000) begin
        next_busy = 1'b0;
        next_wpl = 1'b0;
        next_nvw = 1'b0;
      end else begin
        next_timer = timer - 16'h0001;
      end
    end
    if (SPI_CE_N_I) begin
      next_state = ST_CMD;
      next_cnt = 6'h00;
      next_idx = 3'h0;
      next_so_oe_n = 1'b1;
    end else begin
      if (rise) begin
        next_sh = in_byte;
        if (cnt != BITS_MAX) begin
          next_cnt = cnt + 6'h01;
        end
        if (state == ST_CMD && cnt == BITS_CMD - 6'h01) begin
          next_cmd = in_byte;
          if (busy && !allowed) begin
            next_state = ST_SKIP;
          end else begin
            unique case (in_byte)
              OPC_STATUS_READ: next_state = ST_DATA;
              OPC_PROG, OPC_PROG_Q1, OPC_PROG_Q2, OPC_SEC_ERASE1,
              OPC_SEC_ERASE2, OPC_BLK32_ERASE, OPC_BLK64_ERASE:
                next_state = ST_ADDR;
              OPC_STATUS_WRITE, OPC_WRITE_PERMIT, OPC_WRITE_FORBID,
              OPC_CHIP_ERASE1, OPC_CHIP_ERASE2, OPC_RESET, OPC_SUSPEND,
              OPC_RESUME: next_state = ST_CMD;
              default: next_state = ST_SKIP;
            endcase
          end
        end
        if (state == ST_ADDR) begin
          next_addr = {addr[22:0], SPI_SI_I};
          if (cnt == BITS_ADDR - 6'h01) begin
            next_state = ST_DATA;
          end
        end
        if (cmd == OPC_STATUS_WRITE && cnt == BITS_WDATA - 6'h01) begin
          next_wdata = in_byte;
        end
      end
      // Fresh snapshot per byte so polling sees busy fall
      if (fall && state == ST_DATA && cmd == OPC_STATUS_READ) begin
        next_so_oe_n = 1'b0;
        next_idx = idx + 3'h1;
        if (idx == 3'h0) begin
          next_snap = status;
          next_so = status[7];
        end else begin
          next_so = snap[3'h7 - idx];
        end
      end
    end
    // Frame-end actions
    if (exec) begin
      unique case (cmd)
        OPC_WRITE_PERMIT: next_wpl = 1'b1;
        OPC_WRITE_FORBID: next_wpl = 1'b0;
        OPC_STATUS_WRITE: begin
          // Latch untouched here; cleared when the write ends
          if (cnt >= BITS_WDATA && wpl && (!nv[LOCK_BIT-2] || wp_eff)) begin
            next_nv = wdata[7:2];
            next_busy = 1'b1;
            next_nvw = 1'b1;
            next_timer = OP_CYCLES;
          end
        end
        OPC_PROG, OPC_PROG_Q1, OPC_PROG_Q2, OPC_SEC_ERASE1, OPC_SEC_ERASE2,
        OPC_BLK32_ERASE, OPC_BLK64_ERASE, OPC_CHIP_ERASE1,
        OPC_CHIP_ERASE2: begin
          if (wpl && ((cmd == OPC_CHIP_ERASE1 || cmd == OPC_CHIP_ERASE2)
              ? (nv[3:0] == 4'h0) : (cnt >= BITS_ADDR && !prot))) begin
            next_busy = 1'b1;
            next_timer = OP_CYCLES;
            next_op_start = 1'b1;
            next_op_code = cmd;
            next_op_sector = addr[SEC_MSB:SEC_LSB];
            next_op_block = addr[SEC_MSB:BLK_LSB];
          end
        end
        OPC_SUSPEND: begin
          if (busy && !nvw) begin
            next_busy = 1'b0;
            next_susp = 1'b1;
          end
        end
        OPC_RESUME: begin
          if (susp && !busy) begin
            next_busy = 1'b1;
            next_susp = 1'b0;
          end
        end
        OPC_RESET: begin
          // Software reset abandons work; array content may be lost
          next_busy = 1'b0;
          next_wpl = 1'b0;
          next_susp = 1'b0;
          next_nvw = 1'b0;
          next_timer = 16'h0000;
        end
        default: ;
      endcase
    end
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state <= ST_CMD;
      sck_q <= 1'b0;
      ce_q <= 1'b1;
      cnt <= 6'h00;
      sh <= 8'h00;
      cmd <= 8'h00;
      wdata <= 8'h00;
      snap <= 8'h00;
      addr <= 24'h000000;
      idx <= 3'h0;
      so <= 1'b0;
      so_oe_n <= 1'b1;
      busy <= STATUS_RESET[BUSY_BIT];
      wpl <= STATUS_RESET[WPL_BIT];
      susp <= 1'b0;
      nvw <= 1'b0;
      nv <= STATUS_RESET[7:2];
      timer <= 16'h0000;
      op_start <= 1'b0;
      op_code <= 8'h00;
      op_sector <= 9'h000;
      op_block <= 5'h00;
    end else if (CLK_EN_I) begin
      state <= next_state;
      sck_q <= next_sck_q;
      ce_q <= next_ce_q;
      cnt <= next_cnt;
      sh <= next_sh;
      cmd <= next_cmd;
      wdata <= next_wdata;
      snap <= next_snap;
      addr <= next_addr;
      idx <= next_idx;
      so <= next_so;
      so_oe_n <= next_so_oe_n;
      busy <= next_busy;
      wpl <= next_wpl;
      susp <= next_susp;
      nvw <= next_nvw;
      nv <= next_nv;
      timer <= next_timer;
      op_start <= next_op_start;
      op_code <= next_op_code;
      op_sector <= next_op_sector;
      op_block <= next_op_block;
    end
  end

  // Outputs straight from flip-flops
  assign SPI_SO_O = so;
  assign SPI_SO_OE_N_O = so_oe_n;
  assign QUAD_ON_O = nv[QIO_BIT-2];
  assign BUSY_O = busy;
  assign SUSPENDED_O = susp;
  assign OP_START_O = op_start;
  assign OP_CODE_O = op_code;
  assign OP_SECTOR_O = op_sector;
  assign OP_BLOCK_O = op_block;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  logic status_write_cmd_exec;
  assign status_write_cmd_exec = CLK_EN_I && exec && cmd == OPC_STATUS_WRITE;

  a_read_repeats: assert property (
    CLK_EN_I && fall && state == ST_DATA && cmd == OPC_STATUS_READ
      && idx == 3'h0 |=> snap == $past(status) && SPI_SO_O == snap[7]
      && !SPI_SO_OE_N_O)
    else $error("status byte not reloaded");
  a_busy_drops_cmd: assert property (
    CLK_EN_I && rise && state == ST_CMD && cnt == 6'h07 && busy && !allowed
      |=> state == ST_SKIP)
    else $error("instruction accepted while busy");
  a_status_write_cmd_keeps_wpl: assert property (
    status_write_cmd_exec && !busy |=> wpl == $past(wpl))
    else $error("status write moved the permit latch");
  a_done_clears: assert property (
    CLK_EN_I && busy && timer == 16'h0000 |=> !BUSY_O && !wpl)
    else $error("busy or latch left set at end");
  a_protect_blocks: assert property (
    CLK_EN_I && exec && cmd != OPC_CHIP_ERASE1 && cmd != OPC_CHIP_ERASE2
      && prot |=> !OP_START_O)
    else $error("write started in protected area");
  a_lock_holds: assert property (
    status_write_cmd_exec && nv[LOCK_BIT-2] && !wp_eff |=> $stable(nv))
    else $error("locked status register changed");
  a_nv_source: assert property (
    CLK_EN_I && nv != next_nv |-> status_write_cmd_exec)
    else $error("non-volatile bits changed without status write");
  a_op_busy: assert property (
    OP_START_O |-> BUSY_O && timer >= OP_CYCLES - 16'h0001)
    else $error("operation start without busy");
  a_suspend_taken: assert property (
    CLK_EN_I && exec && cmd == OPC_SUSPEND && busy && !nvw
      |=> !BUSY_O && SUSPENDED_O)
    else $error("suspend not honoured");
  a_quad_follows: assert property (
    $changed(QUAD_ON_O) |-> $past(status_write_cmd_exec) && QUAD_ON_O == $past(wdata[6]))
    else $error("quad output moved without a status write");

  c_read_two_bytes: cover property (
    fall && state == ST_DATA && cmd == OPC_STATUS_READ && idx == 3'h0
      && cnt >= BITS_WDATA);
  c_status_write_cmd_done: cover property (nvw && busy && timer == 16'h0000);
  c_prog_start: cover property (OP_START_O);
  c_suspend: cover property (SUSPENDED_O && !BUSY_O);
endmodule
`default_nettype wire

// File: test/fsr_host.sv
// Behavioural SPI host for the status register bank, mode 0, MSB first.
// Assumes the bench clock; every pin change lands on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module fsr_host (
  input wire logic clk_i,
  input wire logic so_i,
  output logic sck_o,
  output logic ce_n_o,
  output logic si_o
);
  // Idle: deselected, clock parked low
  initial begin
    sck_o = 1'b0;
    ce_n_o = 1'b1;
    si_o = 1'b0;
  end

  // Two reference cycles per phase, twice the least the bank accepts
  task automatic phase(input logic lvl);
    sck_o = lvl;
    repeat (2) @(negedge clk_i);
  endtask

  // Shift nb bits of d out, then clock nr bits of SO back in
  task automatic xfer(input int nb, input logic [31:0] d, input int nr,
                      output logic [15:0] r);
    r = 16'h0000;
    ce_n_o = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      si_o = d[i];
      phase(1'b0);
      phase(1'b1);
    end
    // SI toggles during readback so a stale bit is never mistaken
    for (int i = 0; i < nr; i++) begin
      si_o = ~si_o;
      phase(1'b0);
      r = {r[14:0], so_i};
      phase(1'b1);
    end
    phase(1'b0);
    ce_n_o = 1'b1;
    // Gap of three cycles, above the one the bank needs
    repeat (3) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// File: test/test_flash_status_register_bank.sv
// Self-checking bench for the status register bank: reset, latch, status
// writes, lock, protection, program, suspend and software reset.
// Assumes fsr_host drives the SPI pins; bench inputs move at falling edges.
`timescale 1ns/1ps
`default_nettype none
module test_flash_status_register_bank
  import fsr_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic sck, ce_n, si, so, so_oe_n, quad, busy, susp, start;
  logic so_pin;
  logic [7:0] op_code;
  logic [8:0] op_sec;
  logic [4:0] op_blk;
  logic [15:0] r;
  logic [7:0] s, v;
  logic [23:0] a;
  int seed, bad_count, compares, starts, n;

  always #50 clk = ~clk;

  // No pull on SO: a released pin reads inverted, so stale bits cannot pass
  assign so_pin = so_oe_n ? ~so : so;

  fsr_host u_fsr_host (.clk_i(clk), .so_i(so_pin), .sck_o(sck),
    .ce_n_o(ce_n), .si_o(si));

  // Clock enable tied high; freezing is outside these scenarios
  fsr_bank u_fsr_bank (.REF_CLK_I(clk), .RST_I(rst), .CLK_EN_I(1'b1),
    .SPI_SCK_I(sck), .SPI_CE_N_I(ce_n), .SPI_SI_I(si), .SPI_WP_N_I(wp_n),
    .SPI_SO_O(so), .SPI_SO_OE_N_O(so_oe_n), .QUAD_ON_O(quad),
    .BUSY_O(busy), .SUSPENDED_O(susp), .OP_START_O(start),
    .OP_CODE_O(op_code), .OP_SECTOR_O(op_sec), .OP_BLOCK_O(op_blk));

  // Count accepted program/erase pulses mid-cycle, where they have settled
  always @(negedge clk) begin
    if (start === 1'b1) starts++;
  end

  function automatic logic [7:0] stat(logic [7:0] nv, logic wpl, logic b);
    return {nv[7:2], wpl, b};
  endfunction

  task automatic test_done;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(output logic [7:0] q);
    u_fsr_host.xfer(8, 32'(OPC_STATUS_READ), 8, r);
    q = r[7:0];
  endtask

  task automatic cmd(input logic [7:0] op);
    u_fsr_host.xfer(8, 32'(op), 0, r);
  endtask

  task automatic wr(input logic [7:0] d);
    u_fsr_host.xfer(16, {16'h0000, OPC_STATUS_WRITE, d}, 0, r);
  endtask

  task automatic prog(input logic [7:0] op, input logic [23:0] ad);
    u_fsr_host.xfer(32, {op, ad}, 0, r);
  endtask

  // Poll until ready; a bounded count of frames cuts a hang short
  task automatic wait_ready;
    n = 0;
    do begin
      rd(s);
      n++;
    end while (s[0] !== 1'b0 && n < 80);
    if (s[0] !== 1'b0) begin
      bad_count++;
      test_done;
    end
  endtask

  initial begin
    seed = 19;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    rd(s);
    chk(16'(s), 16'h0000);
    chk(16'(so_oe_n), 16'h0001);
    wr(8'h40);
    rd(s);
    chk(16'(s), 16'h0000);
    cmd(OPC_WRITE_PERMIT);
    rd(s);
    chk(16'(s), 16'h0002);
    cmd(OPC_WRITE_FORBID);
    rd(s);
    chk(16'(s), 16'h0000);
    $display("test latch done");
    // Random status values, lock kept clear so writes succeed
    for (int k = 0; k < 3; k++) begin
      v = 8'($random(seed)) & 8'h7c;
      cmd(OPC_WRITE_PERMIT);
      wr(v);
      chk(16'(busy), 16'h0001);
      u_fsr_host.xfer(8, 32'(OPC_STATUS_READ), 16, r);
      chk(16'(r[15:8]), 16'(stat(v, 1'b1, 1'b1)));
      chk(16'(r[7:0]), 16'(stat(v, 1'b1, 1'b1)));
      cmd(OPC_WRITE_FORBID);
      rd(s);
      chk(16'(s), 16'(stat(v, 1'b1, 1'b1)));
      wait_ready;
      chk(16'(s), 16'(stat(v, 1'b0, 1'b0)));
      chk(16'(quad), 16'(v[6]));
    end
    $display("test status write done");
    cmd(OPC_WRITE_PERMIT);
    wr(8'h80);
    wait_ready;
    wp_n = 1'b0;
    cmd(OPC_WRITE_PERMIT);
    wr(8'h3c);
    chk(16'(busy), 16'h0000);
    rd(s);
    chk(16'(s), 16'h0082);
    wp_n = 1'b1;
    wr(8'h04);
    wait_ready;
    chk(16'(s), 16'h0004);
    $display("test lock done");
    // Code 0001 guards the top block only
    cmd(OPC_WRITE_PERMIT);
    a = 24'h1f0000 | 24'($random(seed) & 32'h0000ffff);
    prog(OPC_SEC_ERASE2, a);
    chk(16'(busy), 16'h0000);
    cmd(OPC_CHIP_ERASE1);
    chk(16'(busy), 16'h0000);
    n = starts;
    a = 24'($random(seed) & 32'h000fffff);
    prog(OPC_PROG, a);
    chk(16'(starts - n), 16'h0001);
    chk(16'(busy), 16'h0001);
    chk(16'(op_code), 16'(OPC_PROG));
    chk(16'(op_sec), 16'(a[20:12]));
    chk(16'(op_blk), 16'(a[20:16]));
    cmd(OPC_SUSPEND);
    chk(16'(susp), 16'h0001);
    cmd(OPC_RESUME);
    chk(16'({susp, busy}), 16'h0001);
    cmd(OPC_RESET);
    chk(16'(busy), 16'h0000);
    rd(s);
    chk(16'(s), 16'h0004);
    $display("test protect done");
    cmd(OPC_WRITE_PERMIT);
    wr(8'h00);
    wait_ready;
    chk(16'(s), 16'h0000);
    $display("test clear done");
    test_done;
  end
endmodule
`default_nettype wire
